// File: hw/clk_mgr_pkg.sv
package clk_mgr_pkg;

    // Timing base
    localparam int CLK_MHZ         = 100;              // clock_in rate
    localparam int XTAL_SETTLE_US  = 1000;             // Fast crystal settle, 1 ms
    localparam int XTAL_SETTLE_CYC = XTAL_SETTLE_US * CLK_MHZ;
    localparam int SLOW_SETTLE_MS  = 1000;             // Slow crystal settle, 1 second
    localparam int SLOW_SETTLE_CYC = SLOW_SETTLE_MS * 1000 * CLK_MHZ;
    localparam int XCNT_W          = 17;
    localparam int SCNT_W          = 27;

    // Register bus
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CLK_CTRL  = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_RC_TRIM   = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_SLOW_CTRL = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_STATUS    = 4'h3;

    // Clock control fields
    localparam int CTRL_SRC_BIT    = 0;
    localparam int CTRL_MANUAL_BIT = 1;
    localparam int CTRL_DIV_LSB    = 2;
    localparam int DIV_SEL_W       = 3;
    localparam logic [DIV_SEL_W-1:0] DIV_SEL_RESET = 3'h1;    // Divide by two
    localparam logic [DIV_SEL_W-1:0] DIV_SEL_MAX   = 3'h5;    // Divide by 32

    // Slow clock control fields
    localparam int SLOW_PULL_LSB = 2;
    localparam logic [1:0] PULL_RESET = 2'h3;
    localparam logic [7:0] TRIM_RESET = 8'h00;

    // Status fields
    localparam int STAT_RC_BIT     = 0;
    localparam int STAT_XRDY_BIT   = 1;
    localparam int STAT_SRDY_BIT   = 2;
    localparam int STAT_SLEEP_BIT  = 3;
    localparam int STAT_SRC_LSB    = 4;

    // Edge counter of the derived clocks
    localparam int EDGE_CNT_W = 6;
    localparam logic [EDGE_CNT_W-1:0] EDGE_WRAP = 6'h3F;

    typedef enum logic [1:0] {
        SLOW_RC   = 2'b00,
        SLOW_XTAL = 2'b01,
        SLOW_EXT  = 2'b10
    } slow_src_t;

endpackage : clk_mgr_pkg

// File: hw/bit_sync.sv
`timescale 1ns/1ps
module bit_sync
#(
    parameter int WIDTH = 1
)
(
    input  wire logic             clock_in,  // System clock
    input  wire logic             rst_b_in,  // Async reset, active low
    input  wire logic [WIDTH-1:0] async_in,  // Foreign-domain levels
    output logic      [WIDTH-1:0] sync_out   // Two-stage synchronised
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    sync_state_t state_q;
    sync_state_t state_d;

    // First stage feeds only the second
    always_comb
    begin
        state_d.meta   = async_in;
        state_d.stable = state_q.meta;
    end

    always_ff @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            state_q <= '0;
        else
            state_q <= state_d;
    end

    assign sync_out = state_q.stable;

endmodule : bit_sync

// File: hw/system_clock_manager.sv
// How it works
// - System clock from fast crystal or RC
// - Peripheral clock is system clock halved
// - Reset starts on RC, auto crystal switch
// - CPU runs at once after reset
// - Wake starts on RC, auto switch again
// - Manual option cancels auto switch after sleep
// - Software selects source; status shows RC active
// - RC trim value drives oscillator frequency
// - CPU clock defaults to divide by two
// - CPU divider factors 1 through 32
// - Slow domain from RC, crystal or module
// - External slow source never reverts to RC
// - Slow crystal: immediate switch, ready after settle
// - Slow crystal disables both pin pull-ups
// - External slow source forces pin 0 to input
// - Slow domain runs, ticks wake timers
// - Sleep halts CPU; four sources wake it
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ps
module system_clock_manager
    import clk_mgr_pkg::*;
#(
    parameter logic [XCNT_W-1:0] XTAL_SETTLE_CYCLES = XCNT_W'(XTAL_SETTLE_CYC),
    parameter logic [SCNT_W-1:0] SLOW_SETTLE_CYCLES = SCNT_W'(SLOW_SETTLE_CYC)
)
(
    input  wire logic              clock_in,                 // 100 MHz clock
    input  wire logic              rst_b_in,                 // Async reset, active low
    input  wire logic [ADDR_W-1:0] reg_addr_in,              // Register index
    input  wire logic [DATA_W-1:0] reg_wdata_in,             // Write data
    input  wire logic              reg_wr_in,                // Write strobe
    input  wire logic              reg_rd_in,                // Read strobe
    output logic      [DATA_W-1:0] reg_rdata_out,            // Read data, next cycle
    input  wire logic              rc_osc_in,                // Fast RC oscillator
    input  wire logic              xtal_osc_in,              // Fast crystal oscillator
    output logic                   xtal_en_out,              // Fast crystal enable
    output logic      [7:0]        rc_trim_out,              // RC calibration trim
    output logic                   periph_clk_out,           // Peripheral clock
    output logic                   periph_tick_out,          // Peripheral rising edge
    output logic                   cpu_clk_out,              // CPU clock
    output logic                   cpu_run_out,              // CPU allowed to run
    input  wire logic              sleep_req_in,             // Enter sleep, pulse
    input  wire logic              wake_timer_irq_in,        // Wake timer event
    input  wire logic              wake_pin_irq_in,          // Pin event
    input  wire logic              wake_cmp_irq_in,          // Comparator event
    input  wire logic              wake_pcnt_irq_in,         // Pulse counter event
    input  wire logic              slow_rc_osc_in,           // Slow RC oscillator
    input  wire logic              slow_clock_input_pin_in,  // Slow crystal or module
    output logic                   slow_clk_out,             // Slow domain clock
    output logic                   slow_tick_out,            // Slow rising edge
    output logic                   slow_xtal_en_out,         // Slow crystal enable
    input  wire logic [1:0]        pin_oe_req_in,            // Pin drive requests
    output logic      [1:0]        pin_oe_out,               // Pin output enables
    output logic      [1:0]        pin_pullup_out            // Pin pull-up enables
);

    typedef struct packed {
        logic                    asleep;
        logic                    act_xtal;
        logic                    want_xtal;
        logic                    manual;
        logic [DIV_SEL_W-1:0]    div_sel;
        logic [DIV_SEL_W-1:0]    div_pend;
        logic [7:0]              trim;
        logic [XCNT_W-1:0]       xcnt;
        logic                    xrdy;
        logic [EDGE_CNT_W-1:0]   cnt;
        logic                    periph;
        logic                    periph_tick;
        logic                    cpu;
        logic                    rc_prev;
        logic                    xt_prev;
        slow_src_t               slow_src;
        logic [SCNT_W-1:0]       scnt;
        logic                    srdy;
        logic                    slow_lvl;
        logic                    slow_tick;
        logic [1:0]              pull;
        logic [1:0]              pin_oe;
        logic [1:0]              pin_pu;
        logic [DATA_W-1:0]       rdata;
    } mgr_state_t;

    mgr_state_t state_q;
    mgr_state_t state_d;
    logic [3:0] osc_s;

    // Mask of edge counts at which the CPU clock toggles
    function automatic logic [EDGE_CNT_W-1:0] div_mask(input logic [DIV_SEL_W-1:0] sel);
        logic [EDGE_CNT_W-1:0] one;
        one = 6'h01;
        return (one << sel) - one;
    endfunction : div_mask

    // Foreign oscillators and pins pass two flops
    bit_sync #(
        .WIDTH    (4)
    ) u_osc_sync (
        .clock_in (clock_in),
        .rst_b_in (rst_b_in),
        .async_in ({slow_clock_input_pin_in, slow_rc_osc_in, xtal_osc_in, rc_osc_in}),
        .sync_out (osc_s)
    );

    always_comb
    begin
        logic            rc_edge;
        logic            xt_edge;
        logic            sys_edge;
        logic            wake_any;
        logic            slow_now;
        logic [DIV_SEL_W-1:0] new_div;
        slow_src_t       new_src;
        rc_edge  = 1'b0;
        xt_edge  = 1'b0;
        sys_edge = 1'b0;
        wake_any = 1'b0;
        slow_now = 1'b0;
        new_div  = '0;
        new_src  = SLOW_RC;
        state_d  = state_q;

        // Both edges of the chosen oscillator step the dividers
        rc_edge  = osc_s[0] ^ state_q.rc_prev;
        xt_edge  = osc_s[1] ^ state_q.xt_prev;
        sys_edge = state_q.act_xtal ? xt_edge : rc_edge;
        state_d.rc_prev     = osc_s[0];
        state_d.xt_prev     = osc_s[1];
        state_d.periph_tick = 1'b0;

        // Crystal counted stable only after full settle time
        if (state_q.asleep)
        begin
            state_d.xcnt = '0;
            state_d.xrdy = 1'b0;
        end
        else if (!state_q.xrdy)
        begin
            if (state_q.xcnt >= XTAL_SETTLE_CYCLES - XCNT_W'(1))
                state_d.xrdy = 1'b1;
            else
                state_d.xcnt = state_q.xcnt + XCNT_W'(1);
        end

        // Derived clocks; divider changes only at wrap, source at wrap or on sleep entry
        if (!state_q.asleep && sys_edge)
        begin
            state_d.cnt = state_q.cnt + EDGE_CNT_W'(1);
            if (state_q.cnt[0])
            begin
                state_d.periph      = !state_q.periph;
                state_d.periph_tick = !state_q.periph;
            end
            if ((state_q.cnt & div_mask(state_q.div_sel)) == div_mask(state_q.div_sel))
                state_d.cpu = !state_q.cpu;
            // All derived clocks fall to low on this edge, so no pulse is cut
            if (state_q.cnt == EDGE_WRAP)
            begin
                state_d.div_sel = state_q.div_pend;
                if (state_q.want_xtal && state_q.xrdy)
                    state_d.act_xtal = 1'b1;
                else if (!state_q.want_xtal)
                    state_d.act_xtal = 1'b0;
            end
        end

        // Slow domain source; oscillator cell sits on the input pin
        unique case (state_q.slow_src)
            SLOW_RC:   slow_now = osc_s[2];
            SLOW_XTAL: slow_now = osc_s[3];
            SLOW_EXT:  slow_now = osc_s[3];
            default:   slow_now = osc_s[2];
        endcase
        state_d.slow_lvl  = slow_now;
        state_d.slow_tick = slow_now && !state_q.slow_lvl;

        // Slow crystal is used at once; ready follows the settle count
        if (state_q.slow_src != SLOW_XTAL)
        begin
            state_d.scnt = '0;
            state_d.srdy = 1'b0;
        end
        else if (!state_q.srdy)
        begin
            if (state_q.scnt >= SLOW_SETTLE_CYCLES - SCNT_W'(1))
                state_d.srdy = 1'b1;
            else
                state_d.scnt = state_q.scnt + SCNT_W'(1);
        end

        // Pin control follows the slow source
        state_d.pin_pu[0] = (state_q.slow_src == SLOW_XTAL) ? 1'b0 : state_q.pull[0];
        state_d.pin_pu[1] = (state_q.slow_src == SLOW_XTAL) ? 1'b0 : state_q.pull[1];
        state_d.pin_oe[0] = (state_q.slow_src != SLOW_RC) ? 1'b0 : pin_oe_req_in[0];
        state_d.pin_oe[1] = (state_q.slow_src == SLOW_XTAL) ? 1'b0 : pin_oe_req_in[1];

        // Register writes
        if (reg_wr_in)
        begin
            unique case (reg_addr_in)
                ADDR_CLK_CTRL:
                begin
                    new_div           = reg_wdata_in[CTRL_DIV_LSB +: DIV_SEL_W];
                    state_d.want_xtal = reg_wdata_in[CTRL_SRC_BIT];
                    state_d.manual    = reg_wdata_in[CTRL_MANUAL_BIT];
                    if (new_div <= DIV_SEL_MAX)
                        state_d.div_pend = new_div;
                end
                ADDR_RC_TRIM:
                    state_d.trim = reg_wdata_in;
                ADDR_SLOW_CTRL:
                begin
                    new_src      = slow_src_t'(reg_wdata_in[1:0]);
                    state_d.pull = reg_wdata_in[SLOW_PULL_LSB +: 2];
                    // Illegal code and any return to RC are dropped
                    if (new_src == SLOW_XTAL || new_src == SLOW_EXT)
                        state_d.slow_src = new_src;
                end
                default:
                    state_d.trim = state_q.trim;
            endcase
        end

        // Sleep entry stops the CPU and drops back to RC
        wake_any = wake_timer_irq_in | wake_pin_irq_in | wake_cmp_irq_in | wake_pcnt_irq_in;
        if (!state_q.asleep && sleep_req_in)
        begin
            state_d.asleep   = 1'b1;
            state_d.act_xtal = 1'b0;
            state_d.cnt      = '0;
            state_d.periph   = 1'b0;
            state_d.cpu      = 1'b0;
        end
        else if (state_q.asleep && wake_any)
        begin
            state_d.asleep    = 1'b0;
            state_d.want_xtal = !state_q.manual;
        end

        // Read data stand only in the cycle after the strobe
        state_d.rdata = '0;
        if (reg_rd_in)
        begin
            unique case (reg_addr_in)
                ADDR_CLK_CTRL:
                begin
                    state_d.rdata[CTRL_SRC_BIT]                   = state_q.want_xtal;
                    state_d.rdata[CTRL_MANUAL_BIT]                = state_q.manual;
                    state_d.rdata[CTRL_DIV_LSB +: DIV_SEL_W]      = state_q.div_pend;
                end
                ADDR_RC_TRIM:
                    state_d.rdata = state_q.trim;
                ADDR_SLOW_CTRL:
                begin
                    state_d.rdata[1:0]                = state_q.slow_src;
                    state_d.rdata[SLOW_PULL_LSB +: 2] = state_q.pull;
                end
                ADDR_STATUS:
                begin
                    state_d.rdata[STAT_RC_BIT]    = !state_q.act_xtal;
                    state_d.rdata[STAT_XRDY_BIT]  = state_q.xrdy;
                    state_d.rdata[STAT_SRDY_BIT]  = state_q.srdy;
                    state_d.rdata[STAT_SLEEP_BIT] = state_q.asleep;
                    state_d.rdata[STAT_SRC_LSB +: 2] = state_q.slow_src;
                end
                default:
                    state_d.rdata = '0;
            endcase
        end
    end

    // Reset: RC source, auto switch armed, CPU free to run
    always_ff @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            state_q           <= '0;
            state_q.want_xtal <= 1'b1;
            state_q.div_sel   <= DIV_SEL_RESET;
            state_q.div_pend  <= DIV_SEL_RESET;
            state_q.trim      <= TRIM_RESET;
            state_q.slow_src  <= SLOW_RC;
            state_q.pull      <= PULL_RESET;
            state_q.pin_pu    <= PULL_RESET;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // Outputs straight from flops
    assign reg_rdata_out    = state_q.rdata;
    assign xtal_en_out      = !state_q.asleep;
    assign rc_trim_out      = state_q.trim;
    assign periph_clk_out   = state_q.periph;
    assign periph_tick_out  = state_q.periph_tick;
    assign cpu_clk_out      = state_q.cpu;
    assign cpu_run_out      = !state_q.asleep;
    assign slow_clk_out     = state_q.slow_lvl;
    assign slow_tick_out    = state_q.slow_tick;
    assign slow_xtal_en_out = (state_q.slow_src == SLOW_XTAL);
    assign pin_oe_out       = state_q.pin_oe;
    assign pin_pullup_out   = state_q.pin_pu;

    // Checks
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);

    property p_switch_needs_ready;
        $rose(state_q.act_xtal) |-> $past(state_q.xrdy) && state_q.xrdy;
    endproperty
    a_switch_needs_ready: assert property (p_switch_needs_ready)
        else $error("Crystal selected before ready");

    property p_switch_at_wrap;
        $changed(state_q.act_xtal) |-> state_q.cnt == '0 && !cpu_clk_out && !periph_clk_out;
    endproperty
    a_switch_at_wrap: assert property (p_switch_at_wrap)
        else $error("Source changed mid period");

    property p_sleep_halts;
        sleep_req_in && !state_q.asleep |=> !cpu_run_out && !state_q.act_xtal;
    endproperty
    a_sleep_halts: assert property (p_sleep_halts)
        else $error("Sleep did not halt CPU on RC");

    property p_wake_manual;
        state_q.asleep && state_q.manual
            && (wake_timer_irq_in || wake_pin_irq_in || wake_cmp_irq_in || wake_pcnt_irq_in)
            |=> cpu_run_out && !state_q.want_xtal ##1 !state_q.act_xtal;
    endproperty
    a_wake_manual: assert property (p_wake_manual)
        else $error("Manual start still switched");

    property p_status_rc;
        reg_rd_in && reg_addr_in == ADDR_STATUS && !reg_wr_in
            |=> reg_rdata_out[STAT_RC_BIT] == $past(!state_q.act_xtal);
    endproperty
    a_status_rc: assert property (p_status_rc)
        else $error("Source indicator wrong");

    property p_slow_locked;
        state_q.slow_src != SLOW_RC |=> state_q.slow_src != SLOW_RC;
    endproperty
    a_slow_locked: assert property (p_slow_locked)
        else $error("Slow source reverted to RC");

    property p_xtal_pullups;
        state_q.slow_src == SLOW_XTAL ##1 state_q.slow_src == SLOW_XTAL
            |-> pin_pullup_out == 2'b00 && pin_oe_out == 2'b00;
    endproperty
    a_xtal_pullups: assert property (p_xtal_pullups)
        else $error("Crystal pins not released");

    property p_ext_input;
        state_q.slow_src == SLOW_EXT ##1 state_q.slow_src == SLOW_EXT |-> !pin_oe_out[0];
    endproperty
    a_ext_input: assert property (p_ext_input)
        else $error("Module pin still driven");

    property p_periph_half;
        $rose(periph_clk_out) |-> $past(state_q.cnt[1:0]) == 2'b01;
    endproperty
    a_periph_half: assert property (p_periph_half)
        else $error("Peripheral clock phase wrong");

    property p_div_legal;
        state_q.div_sel <= DIV_SEL_MAX && state_q.div_pend <= DIV_SEL_MAX;
    endproperty
    a_div_legal: assert property (p_div_legal)
        else $error("Illegal divider select");

    c_auto_switch: cover property ($rose(state_q.act_xtal));
    c_sleep_wake:  cover property (state_q.asleep ##1 !state_q.asleep);
    c_slow_ready:  cover property ($rose(state_q.srdy));

endmodule : system_clock_manager

// File: verification/system_clock_manager_tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((ex) !== (got)) begin n_mismatch++; \
$display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module system_clock_manager_tb;
    import clk_mgr_pkg::*;
    logic              clock_in = 0, rst_b_in = 0, reg_wr_in = 0, reg_rd_in = 0;
    logic [ADDR_W-1:0] reg_addr_in = '0;
    logic [DATA_W-1:0] reg_wdata_in = '0, reg_rdata_out, s;
    logic              rc_osc_in = 0, xtal_osc_in = 0, slow_rc_osc_in = 0, slow_pin = 0;
    logic              sleep_req_in = 0, xtal_en_out, periph_clk_out, periph_tick_out;
    logic              cpu_clk_out, cpu_run_out, slow_clk_out, slow_tick_out, slow_xtal_en_out;
    logic [3:0]        wake_v = '0;
    logic [1:0]        pin_oe_req_in = '0, pin_oe_out, pin_pullup_out;
    logic [7:0]        rc_trim_out, t;
    logic              pprev = 0, cprev = 0;
    int                n_mismatch = 0, num_checks = 0, np_c, nc_c, ns_c, prun, cyc = 0;
    int                np, nc, ns, cur;
    longint            t0;
    // Free-running oscillators, unrelated in phase to the bench clock
    always #5 clock_in = ~clock_in;
    always #37 rc_osc_in = ~rc_osc_in;
    always #31 xtal_osc_in = ~xtal_osc_in;
    always #153 slow_rc_osc_in = ~slow_rc_osc_in;
    always #171 slow_pin = ~slow_pin;
    system_clock_manager #(.XTAL_SETTLE_CYCLES(17'd20), .SLOW_SETTLE_CYCLES(27'd50)) dut_u (
        .clock_in(clock_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .rc_osc_in(rc_osc_in), .xtal_osc_in(xtal_osc_in),
        .xtal_en_out(xtal_en_out), .rc_trim_out(rc_trim_out), .periph_clk_out(periph_clk_out),
        .periph_tick_out(periph_tick_out), .cpu_clk_out(cpu_clk_out), .cpu_run_out(cpu_run_out),
        .sleep_req_in(sleep_req_in), .wake_timer_irq_in(wake_v[0]), .wake_pin_irq_in(wake_v[1]),
        .wake_cmp_irq_in(wake_v[2]), .wake_pcnt_irq_in(wake_v[3]),
        .slow_rc_osc_in(slow_rc_osc_in), .slow_clock_input_pin_in(slow_pin),
        .slow_clk_out(slow_clk_out), .slow_tick_out(slow_tick_out),
        .slow_xtal_en_out(slow_xtal_en_out), .pin_oe_req_in(pin_oe_req_in),
        .pin_oe_out(pin_oe_out), .pin_pullup_out(pin_pullup_out));
    // Edge counters and shortest-level watch on the peripheral clock
    always @(posedge clock_in)
    begin
        cyc++;
        if (periph_tick_out === 1'b1) np_c++;
        if (slow_tick_out === 1'b1) ns_c++;
        if (cpu_clk_out === 1'b1 && cprev === 1'b0) nc_c++;
        cprev = cpu_clk_out;
        if (periph_clk_out !== pprev)
        begin
            if (rst_b_in && cpu_run_out === 1'b1) `CHK("periph_level_len", 1'b1, prun >= 2)
            prun = 1;
        end
        else prun++;
        pprev = periph_clk_out;
        if (cyc == 60000)
        begin
            n_mismatch++;
            give_verdict();
        end
    end
    function automatic logic near(input int a, input int b, input int tol);
        return (a - b <= tol) && (b - a <= tol);
    endfunction : near
    // Rising CPU edges expected for a count of peripheral ticks at divider d
    function automatic int cpu_exp(input int p, input int d);
        return (p * 4) >> (d + 1);
    endfunction : cpu_exp
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clock_in);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_wr_in    <= 1'b1;
        @(posedge clock_in);
        reg_wr_in <= 1'b0;
        // Let the written value settle before anyone looks at outputs
        #1;
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clock_in);
        reg_addr_in <= a;
        reg_rd_in   <= 1'b1;
        @(posedge clock_in);
        reg_rd_in <= 1'b0;
        #1 d = reg_rdata_out;
    endtask : rd
    // Bounded poll of one status bit
    task automatic wait_stat(input int b, input logic v, output logic [DATA_W-1:0] q);
        for (int i = 0; i < 600; i++)
        begin
            rd(ADDR_STATUS, q);
            if (q[b] === v) break;
        end
    endtask : wait_stat
    // Settle past a counter wrap, then count edges over 1500 cycles
    task automatic measure();
        repeat (300) @(posedge clock_in);
        #1;
        np_c = 0;
        nc_c = 0;
        ns_c = 0;
        repeat (1500) @(posedge clock_in);
        np = np_c;
        nc = nc_c;
        ns = ns_c;
    endtask : measure
    task automatic pulse(input int w);
        @(posedge clock_in);
        if (w < 0) sleep_req_in <= 1'b1; else wake_v[w] <= 1'b1;
        @(posedge clock_in);
        sleep_req_in <= 1'b0;
        wake_v       <= '0;
        #1;
    endtask : pulse
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict
    initial
    begin
        void'($urandom(20));
        repeat (16) @(posedge clock_in);
        rst_b_in <= 1'b1;
        #1 `CHK("xtal_en", 1'b1, xtal_en_out)
        `CHK("cpu_run", 1'b1, cpu_run_out)
        `CHK("pullups", 2'b11, pin_pullup_out)
        `CHK("trim", 8'h00, rc_trim_out)
        rd(ADDR_CLK_CTRL, s); `CHK("clk_ctrl", 8'h05, s)
        rd(ADDR_STATUS, s); `CHK("rc_active", 1'b1, s[STAT_RC_BIT])
        `CHK("xtal_ready", 1'b0, s[STAT_XRDY_BIT])
        `CHK("slow_src", 2'b00, s[STAT_SRC_LSB+:2])
        @(posedge clock_in); #1 `CHK("rdata_idle", 8'h00, reg_rdata_out)
        wait_stat(STAT_RC_BIT, 1'b0, s); `CHK("auto_switch", 1'b0, s[STAT_RC_BIT])
        `CHK("xtal_ready", 1'b1, s[STAT_XRDY_BIT])
        wr(4'h7, 8'hFF); rd(4'h7, s); `CHK("unmapped", 8'h00, s)
        repeat (3)
        begin
            t = 8'($urandom);
            wr(ADDR_RC_TRIM, t); `CHK("trim_out", t, rc_trim_out)
            rd(ADDR_RC_TRIM, s); `CHK("trim_rd", t, s)
        end
        // Every divider code, in a seeded order, with 6 and 7 refused
        cur = 1;
        t = 8'($urandom);
        for (int i = 0; i < 8; i++)
        begin
            wr(ADDR_CLK_CTRL, {3'b0, 3'(i) ^ t[2:0], 2'b01});
            if ((3'(i) ^ t[2:0]) <= DIV_SEL_MAX) cur = int'(3'(i) ^ t[2:0]);
            rd(ADDR_CLK_CTRL, s); `CHK("div_sel", 3'(cur), s[4:2])
            measure();
            `CHK("periph_rate", 1'b1, near(np, 15000 / 124, 3))
            `CHK("cpu_rate", 1'b1, near(nc, cpu_exp(np, cur), 2))
        end
        wr(ADDR_CLK_CTRL, 8'h04);
        wait_stat(STAT_RC_BIT, 1'b1, s); `CHK("sw_to_rc", 1'b1, s[STAT_RC_BIT])
        measure(); `CHK("periph_rc", 1'b1, near(np, 15000 / 148, 3))
        `CHK("cpu_rc", 1'b1, near(nc, np, 2))
        wr(ADDR_CLK_CTRL, 8'h05);
        wait_stat(STAT_RC_BIT, 1'b0, s); `CHK("sw_to_xtal", 1'b0, s[STAT_RC_BIT])
        // Sleep and wake through each source, manual start on odd ones
        for (int w = 0; w < 4; w++)
        begin
            wr(ADDR_CLK_CTRL, {6'h01, 1'(w), 1'b1});
            pulse(-1); `CHK("asleep_run", 1'b0, cpu_run_out)
            repeat (20) @(posedge clock_in);
            rd(ADDR_STATUS, s); `CHK("asleep_flag", 1'b1, s[STAT_SLEEP_BIT])
            `CHK("asleep_rc", 1'b1, s[STAT_RC_BIT])
            pulse(w); `CHK("woke_run", 1'b1, cpu_run_out)
            `CHK("woke_xtal_en", 1'b1, xtal_en_out)
            if (w % 2 == 1)
            begin
                repeat (500) @(posedge clock_in);
                rd(ADDR_STATUS, s); `CHK("manual_stays_rc", 1'b1, s[STAT_RC_BIT])
            end
            else
            begin
                wait_stat(STAT_RC_BIT, 1'b0, s); `CHK("wake_switch", 1'b0, s[STAT_RC_BIT])
            end
        end
        // Slow domain: RC, crystal, refused revert, clock module
        pin_oe_req_in <= 2'b11;
        measure(); `CHK("slow_rc_ticks", 1'b1, near(ns, 15000 / 306, 3))
        `CHK("pins_free", 2'b11, pin_oe_out)
        wr(ADDR_SLOW_CTRL, 8'h0D);
        t0 = $time;
        repeat (3) @(posedge clock_in);
        #1 `CHK("slow_xtal_en", 1'b1, slow_xtal_en_out)
        `CHK("xtal_pullups", 2'b00, pin_pullup_out)
        `CHK("xtal_pins_in", 2'b00, pin_oe_out)
        wait_stat(STAT_SRDY_BIT, 1'b1, s); `CHK("slow_ready", 1'b1, s[STAT_SRDY_BIT])
        `CHK("slow_settle", 1'b1, near(int'(($time - t0) / 10), 55, 8))
        measure(); `CHK("slow_xtal_ticks", 1'b1, near(ns, 15000 / 342, 3))
        wr(ADDR_SLOW_CTRL, 8'h0C);
        rd(ADDR_STATUS, s); `CHK("no_revert", 2'b01, s[STAT_SRC_LSB+:2])
        wr(ADDR_SLOW_CTRL, 8'h02);
        repeat (3) @(posedge clock_in);
        #1 `CHK("module_pin_in", 1'b0, pin_oe_out[0])
        `CHK("module_pullup", 1'b0, pin_pullup_out[0])
        wr(ADDR_SLOW_CTRL, 8'h00);
        rd(ADDR_STATUS, s); `CHK("module_kept", 2'b10, s[STAT_SRC_LSB+:2])
        give_verdict();
    end
endmodule : system_clock_manager_tb
